//--- logic/register_map_page_select.v
// register map and sub map selection behind the two-wire config port
//
// Summary of operation
// - main map answers 0x40/0x41 or 0x42/0x43 by pin
// - bits 6:5 of 0x0E select sub map
// - all sub maps share the main slave address
// - page field resets to user sub map
// - postproc map address from 0xFD bits 7:1
// - postproc address resets 0x00, silent until programmed
// - serial-output map address from 0xFE bits 7:1
// - serial-output address resets 0x00, silent until programmed
// - programmable maps ignore pin and page field
// - 0x0E writable in second user sub map too
`timescale 1ns/1ps
`include "register_map_page_select_defines.vh"

module register_map_page_select (
    input  wire       clk,
    input  wire       reset_n,
    input  wire       addressSelectPin,
    input  wire       startSeen,
    input  wire       stopSeen,
    input  wire       addrValid,
    input  wire [7:0] addrByte,
    input  wire       wrValid,
    input  wire [7:0] wrData,
    input  wire       rdReq,
    input  wire [7:0] mapRdData,
    output reg        ackValid,
    output reg        ackBit,
    output reg        rdValid,
    output reg  [7:0] rdData,
    output reg        mapWrite,
    output reg        mapRead,
    output reg  [2:0] mapSel,
    output reg  [7:0] mapSubaddr,
    output reg  [7:0] mapWrData,
    output reg  [1:0] activePage
);

    // -----------------------------------------------------------------
    // states
    // -----------------------------------------------------------------
    localparam ST_IDLE = 2'h0;
    localparam ST_SUB  = 2'h1;
    localparam ST_WR   = 2'h2;
    localparam ST_RD   = 2'h3;

    reg  [1:0] state_reg;
    reg  [1:0] state_next;
    reg  [1:0] pinSync_reg;
    reg  [7:0] pageSel_reg;
    reg  [7:0] ppAddr_reg;
    reg  [7:0] serAddr_reg;
    reg  [2:0] txnMap_reg;
    reg  [7:0] subPtr_reg;
    reg        rdPend_reg;
    reg        rdLocal_reg;
    reg  [7:0] rdLocalData_reg;
    reg  [2:0] addrMap;
    wire       mainHit;
    wire [1:0] progHit;
    wire [7:0] progAddr [0:1];
    wire [7:0] subPtrInc;
    wire       takeAddr;
    wire       takeSub;
    wire       takeData;
    wire       takeRead;
    wire       ptrLocal;

    // -----------------------------------------------------------------
    // decode helpers
    // -----------------------------------------------------------------
    function isLocal;
        input [2:0] map;
        input [7:0] sub;
        begin
            isLocal = ((map == `MAP_USER) &&
                       ((sub == `OFS_SUB_MAP_PAGE) ||
                        (sub == `OFS_POSTPROC_ADDR) ||
                        (sub == `OFS_SERIAL_OUT_ADDR))) ||
                      (((map == `MAP_USER2) ||
                        (map == `MAP_INTR_VBI)) &&
                       (sub == `OFS_SUB_MAP_PAGE));
        end
    endfunction

    function [2:0] pageToMap;
        input [1:0] page;
        begin
            case (page)
                `PAGE_USER:     pageToMap = `MAP_USER;
                `PAGE_INTR_VBI: pageToMap = `MAP_INTR_VBI;
                `PAGE_USER2:    pageToMap = `MAP_USER2;
                default:        pageToMap = `MAP_NONE;
            endcase
        end
    endfunction

    // -----------------------------------------------------------------
    // pin synchroniser
    // -----------------------------------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pinSync_reg <= 2'h0;
        end else begin
            pinSync_reg <= {pinSync_reg[0], addressSelectPin};
        end
    end

    // -----------------------------------------------------------------
    // slave address decode
    // -----------------------------------------------------------------
    assign mainHit = (addrByte[7:1] ==
                      {`MAIN_ADDR_HI6, pinSync_reg[1]});

    assign progAddr[0] = ppAddr_reg;
    assign progAddr[1] = serAddr_reg;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : progMatch
            slave_address_match matcher (
                .addrByte  (addrByte),
                .slaveAddr (progAddr[gi]),
                .hit       (progHit[gi])
            );
        end
    endgenerate

    always @* begin
        if (mainHit) begin
            addrMap = pageToMap(pageSel_reg[`PAGE_MSB:`PAGE_LSB]);
        end else if (progHit[0]) begin
            addrMap = `MAP_POSTPROC;
        end else if (progHit[1]) begin
            addrMap = `MAP_SERIAL_OUT;
        end else begin
            addrMap = `MAP_NONE;
        end
    end

    assign subPtrInc = (subPtr_reg == `OFS_LAST) ?
                       subPtr_reg : subPtr_reg + 8'h01;

    // -----------------------------------------------------------------
    // transaction state machine
    // -----------------------------------------------------------------
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (addrValid && (addrMap != `MAP_NONE)) begin
                    state_next = addrByte[0] ? ST_RD : ST_SUB;
                end
            end
            ST_SUB: begin
                if (wrValid) begin
                    state_next = ST_WR;
                end
            end
            ST_WR: begin
                state_next = ST_WR;
            end
            ST_RD: begin
                state_next = ST_RD;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        if (startSeen || stopSeen) begin
            state_next = ST_IDLE;
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // -----------------------------------------------------------------
    // byte acceptance
    // -----------------------------------------------------------------
    assign takeAddr = (state_reg == ST_IDLE) && addrValid &&
                      !startSeen && !stopSeen;
    assign takeSub  = (state_reg == ST_SUB) && wrValid;
    assign takeData = (state_reg == ST_WR) && wrValid;
    assign takeRead = (state_reg == ST_RD) && rdReq;
    assign ptrLocal = isLocal(txnMap_reg, subPtr_reg);

    // -----------------------------------------------------------------
    // local registers
    // -----------------------------------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pageSel_reg <= `RST_SUB_MAP_PAGE;
            ppAddr_reg  <= `RST_POSTPROC_ADDR;
            serAddr_reg <= `RST_SERIAL_OUT_ADDR;
            activePage  <= `PAGE_USER;
        end else begin
            activePage <= pageSel_reg[`PAGE_MSB:`PAGE_LSB];
            if (takeData && ptrLocal) begin
                if (subPtr_reg == `OFS_SUB_MAP_PAGE) begin
                    pageSel_reg <= wrData;
                end
                if (subPtr_reg == `OFS_POSTPROC_ADDR) begin
                    ppAddr_reg <= wrData;
                end
                if (subPtr_reg == `OFS_SERIAL_OUT_ADDR) begin
                    serAddr_reg <= wrData;
                end
            end
        end
    end

    // -----------------------------------------------------------------
    // transaction map and subaddress pointer
    // -----------------------------------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            txnMap_reg <= `MAP_NONE;
            subPtr_reg <= 8'h00;
        end else begin
            if (takeAddr) begin
                // map is frozen here for the whole transaction
                txnMap_reg <= addrMap;
            end
            if (takeSub) begin
                subPtr_reg <= wrData;
            end else if (takeData || takeRead) begin
                subPtr_reg <= subPtrInc;
            end
        end
    end

    // -----------------------------------------------------------------
    // answers
    // -----------------------------------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ackValid <= 1'b0;
            ackBit   <= 1'b0;
        end else begin
            ackValid <= takeAddr || takeSub || takeData;
            if (takeAddr) begin
                ackBit <= (addrMap != `MAP_NONE);
            end else if (takeSub || takeData) begin
                ackBit <= 1'b1;
            end
        end
    end

    // -----------------------------------------------------------------
    // external map strobes
    // -----------------------------------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mapWrite   <= 1'b0;
            mapRead    <= 1'b0;
            mapSel     <= `MAP_NONE;
            mapSubaddr <= 8'h00;
            mapWrData  <= 8'h00;
        end else begin
            mapWrite <= takeData && !ptrLocal;
            mapRead  <= takeRead && !ptrLocal;
            if ((takeData || takeRead) && !ptrLocal) begin
                mapSel     <= txnMap_reg;
                mapSubaddr <= subPtr_reg;
            end
            if (takeData && !ptrLocal) begin
                mapWrData <= wrData;
            end
        end
    end

    // -----------------------------------------------------------------
    // read return
    // -----------------------------------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdPend_reg      <= 1'b0;
            rdLocal_reg     <= 1'b0;
            rdLocalData_reg <= 8'h00;
            rdValid         <= 1'b0;
            rdData          <= 8'h00;
        end else begin
            rdPend_reg <= takeRead;
            rdValid    <= rdPend_reg;
            if (takeRead) begin
                rdLocal_reg <= ptrLocal;
                if (subPtr_reg == `OFS_SUB_MAP_PAGE) begin
                    rdLocalData_reg <= pageSel_reg;
                end else if (subPtr_reg == `OFS_POSTPROC_ADDR) begin
                    rdLocalData_reg <= ppAddr_reg;
                end else begin
                    rdLocalData_reg <= serAddr_reg;
                end
            end
            if (rdPend_reg) begin
                // local registers answer from the copy taken at the request
                rdData <= rdLocal_reg ? rdLocalData_reg : mapRdData;
            end
        end
    end

endmodule // register_map_page_select

//--- logic/register_map_page_select_defines.vh
// constants for the register map and sub map selection block
`ifndef REGISTER_MAP_PAGE_SELECT_DEFINES_VH
`define REGISTER_MAP_PAGE_SELECT_DEFINES_VH

// ---------------------------------------------------------------------
// slave addresses (main: upper six bits, pin bit excluded; unset: upper seven bits; read/write bit excluded)
// ---------------------------------------------------------------------
`define MAIN_ADDR_HI6          6'h10
`define PROG_ADDR_UNSET        7'h00

// ---------------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------------
`define OFS_SUB_MAP_PAGE       8'h0E
`define OFS_POSTPROC_ADDR      8'hFD
`define OFS_SERIAL_OUT_ADDR    8'hFE
`define OFS_LAST               8'hFF

// ---------------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------------
`define PAGE_MSB               6
`define PAGE_LSB               5
`define RST_SUB_MAP_PAGE       8'h00
`define RST_POSTPROC_ADDR      8'h00
`define RST_SERIAL_OUT_ADDR    8'h00

// ---------------------------------------------------------------------
// page codes and map codes
// ---------------------------------------------------------------------
`define PAGE_USER              2'h0
`define PAGE_INTR_VBI          2'h1
`define PAGE_USER2             2'h2
`define MAP_USER               3'h0
`define MAP_INTR_VBI           3'h1
`define MAP_USER2              3'h2
`define MAP_POSTPROC           3'h3
`define MAP_SERIAL_OUT         3'h4
`define MAP_NONE               3'h7

`endif

//--- logic/slave_address_match.v
// matcher for one programmable slave address
`timescale 1ns/1ps
`include "register_map_page_select_defines.vh"

module slave_address_match (
    input  wire [7:0] addrByte,
    input  wire [7:0] slaveAddr,
    output wire       hit
);

    // an address still at its reset value never answers
    assign hit = (slaveAddr[7:1] != `PROG_ADDR_UNSET) &&
                 (addrByte[7:1] == slaveAddr[7:1]);

endmodule // slave_address_match

//--- verif/map_store_model.sv
// behavioural store standing in for the external register maps
`timescale 1ns/1ps
module map_store_model (
    input  wire       clk,
    input  wire       mapWrite,
    input  wire       mapRead,
    input  wire [2:0] mapSel,
    input  wire [7:0] mapSubaddr,
    input  wire [7:0] mapWrData,
    output wire [7:0] mapRdData
);
    reg [7:0] mem [0:2047];
    reg [7:0] lastRd = 8'h00;
    always @(posedge clk) begin
        if (mapWrite) mem[{mapSel, mapSubaddr}] <= mapWrData;
        if (mapRead) lastRd <= mapRdData;
    end
    // outside a read cycle the bus shows junk, not the last byte
    assign mapRdData = mapRead ? mem[{mapSel, mapSubaddr}] : ~lastRd;
endmodule // map_store_model

//--- verif/register_map_page_select_asserts.sv
// port-level checker for the register map and sub map selection block
`timescale 1ns/1ps
module register_map_page_select_asserts (
    input wire       clk,
    input wire       reset_n,
    input wire       addrValid,
    input wire       wrValid,
    input wire       rdReq,
    input wire [7:0] mapRdData,
    input wire       ackValid,
    input wire       ackBit,
    input wire       rdValid,
    input wire [7:0] rdData,
    input wire       mapWrite,
    input wire       mapRead,
    input wire [2:0] mapSel,
    input wire [1:0] activePage
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_ack_cause: assert property (ackValid |-> $past(addrValid || wrValid))
        else $error("ack without a byte");
    a_read_latency: assert property (rdValid |-> $past(rdReq, 2))
        else $error("read data without request");
    a_mapread_cause: assert property (mapRead |-> $past(rdReq))
        else $error("map read without request");
    a_read_chain: assert property (mapRead |=>
        (rdValid && rdData == $past(mapRdData)))
        else $error("read data not from map");
    a_write_acked: assert property (mapWrite |->
        (ackValid && ackBit && $past(wrValid)))
        else $error("map write not acked");
    a_sel_legal: assert property (mapSel <= 3'h4 || mapSel == 3'h7)
        else $error("illegal map code");
    a_strobe_sel: assert property ((mapWrite || mapRead) |-> mapSel != 3'h7)
        else $error("strobe with no map");
    a_page_change: assert property
        (activePage != $past(activePage) |-> $past(ackValid))
        else $error("page moved without a write");
endmodule // register_map_page_select_asserts

bind register_map_page_select register_map_page_select_asserts u_chk (
    .clk(clk), .reset_n(reset_n), .addrValid(addrValid),
    .wrValid(wrValid), .rdReq(rdReq), .mapRdData(mapRdData),
    .ackValid(ackValid), .ackBit(ackBit), .rdValid(rdValid),
    .rdData(rdData), .mapWrite(mapWrite), .mapRead(mapRead),
    .mapSel(mapSel), .activePage(activePage));

//--- verif/tb.sv
// self-checking bench for the register map and sub map selection block
`timescale 1ns/1ps
module tb;
    reg        clk, reset_n, pin, startSeen, stopSeen;
    reg        addrValid, wrValid, rdReq;
    reg  [7:0] addrByte, wrData, s, d, a;
    reg [31:0] r;
    wire [7:0] mapRdData, rdData, mapSubaddr, mapWrData;
    wire       ackValid, ackBit, rdValid, mapWrite, mapRead;
    wire [2:0] mapSel;
    wire [1:0] activePage;
    integer    failures = 0, n_tests = 0, cyc = 0, seed = 32'h03fc, i;
    localparam [7:0] mainAddr = 8'h42;

    register_map_page_select DUT (.clk(clk), .reset_n(reset_n),
        .addressSelectPin(pin), .startSeen(startSeen), .stopSeen(stopSeen),
        .addrValid(addrValid), .addrByte(addrByte), .wrValid(wrValid),
        .wrData(wrData), .rdReq(rdReq), .mapRdData(mapRdData),
        .ackValid(ackValid), .ackBit(ackBit), .rdValid(rdValid),
        .rdData(rdData), .mapWrite(mapWrite), .mapRead(mapRead),
        .mapSel(mapSel), .mapSubaddr(mapSubaddr), .mapWrData(mapWrData),
        .activePage(activePage));
    map_store_model far (.clk(clk), .mapWrite(mapWrite), .mapRead(mapRead),
        .mapSel(mapSel), .mapSubaddr(mapSubaddr), .mapWrData(mapWrData),
        .mapRdData(mapRdData));

    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            failures = failures + 1;
            test_done;
        end
    end

    task test_done;
        begin
            $display("tests %0d failures %0d", n_tests, failures);
            if (failures == 0 && n_tests > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    task chk(input string n, input [7:0] e, input [7:0] g);
        begin
            n_tests = n_tests + 1;
            if (g !== e) begin
                failures = failures + 1;
                $display("mismatch %s expected %h seen %h", n, e, g);
            end
        end
    endtask
    task frame(input st);
        begin
            @(negedge clk); startSeen = st; stopSeen = !st;
            @(negedge clk); startSeen = 0; stopSeen = 0;
        end
    endtask
    task xbyte(input k, input [7:0] v, input [1:0] e);
        begin
            @(negedge clk); addrValid = !k; wrValid = k;
            addrByte = v; wrData = v;
            @(negedge clk); addrValid = 0; wrValid = 0;
            chk("ack", {6'h00, e}, {6'h00, ackValid, ackBit});
        end
    endtask
    task wrt(input [7:0] ad, input [7:0] sa, input [7:0] d0, input [7:0] d1);
        begin
            frame(1); xbyte(1'b0, ad, 2'h3); xbyte(1'b1, sa, 2'h3);
            xbyte(1'b1, d0, 2'h3); xbyte(1'b1, d1, 2'h3); frame(0);
        end
    endtask
    task rd(input [7:0] ad, input [7:0] sa, input [7:0] e, input [2:0] m);
        begin
            frame(1); xbyte(1'b0, ad, 2'h3); xbyte(1'b1, sa, 2'h3); frame(0);
            frame(1); xbyte(1'b0, ad | 8'h01, 2'h3);
            @(negedge clk); rdReq = 1;
            @(negedge clk); rdReq = 0;
            chk("mapRead", {7'h00, m != 3'h7}, {7'h00, mapRead});
            if (m != 3'h7) chk("mapSel", {5'h00, m}, {5'h00, mapSel});
            @(negedge clk);
            chk("rdValid", 8'h01, {7'h00, rdValid});
            chk("rdData", e, rdData);
            frame(0);
        end
    endtask
    task pg(input [1:0] p);
        begin
            wrt(mainAddr, 8'h0E, {1'b0, p, 5'h00}, 8'h00);
            chk("page", {6'h00, p}, {6'h00, activePage});
            chk("oldMap", 8'h00, {5'h00, mapSel});
            chk("oldSub", 8'h0F, mapSubaddr);
            r = $random(seed); s = {3'h1, r[4:0]}; d = r[15:8];
            wrt(mainAddr, s, d, ~d);
            rd(mainAddr, s, d, {1'b0, p});
            rd(mainAddr, s + 8'h01, ~d, {1'b0, p});
        end
    endtask

    initial begin
        reset_n = 0; pin = 0; startSeen = 0; stopSeen = 0; rdReq = 0;
        addrValid = 0; wrValid = 0; addrByte = 8'h00; wrData = 8'h00;
        repeat (2) @(negedge clk);
        reset_n = 1;
        repeat (3) @(negedge clk);
        chk("page", 8'h00, {6'h00, activePage});
        rd(8'h40, 8'h0E, 8'h00, 3'h7);
        rd(8'h40, 8'hFD, 8'h00, 3'h7);
        rd(8'h40, 8'hFE, 8'h00, 3'h7);
        for (i = 0; i < 2; i = i + 1) begin
            pin = i[0];
            repeat (3) @(negedge clk);
            frame(1); xbyte(1'b0, {6'h10, i[0], 1'b0}, 2'h3); frame(0);
            frame(1); xbyte(1'b0, {6'h10, !i[0], 1'b0}, 2'h2);
            xbyte(1'b1, 8'h0E, 2'h0); frame(0);
        end
        frame(1); xbyte(1'b0, 8'h84, 2'h2); frame(0);
        frame(1); xbyte(1'b0, 8'h88, 2'h2); frame(0);
        pg(2'h0);
        pg(2'h2);
        wrt(mainAddr, 8'h0E, 8'h00, 8'h00);
        chk("page", 8'h00, {6'h00, activePage});
        wrt(mainAddr, 8'hFD, 8'h84, 8'h88);
        pg(2'h1);
        wrt(mainAddr, 8'h0E, 8'h00, 8'h00);
        chk("page", 8'h00, {6'h00, activePage});
        for (i = 0; i < 2; i = i + 1) begin
            a = {4'h8, i[0], !i[0], 2'h0};
            r = $random(seed);
            wrt(a, {1'b0, r[6:0]}, r[15:8], r[23:16]);
            rd(a, {1'b0, r[6:0]}, r[15:8], 3'h3 + {2'h0, i[0]});
        end
        @(negedge clk); reset_n = 0;
        repeat (2) @(negedge clk);
        reset_n = 1;
        repeat (3) @(negedge clk);
        chk("page", 8'h00, {6'h00, activePage});
        frame(1); xbyte(1'b0, 8'h84, 2'h2); frame(0);
        test_done;
    end
endmodule // tb
